// ==== hw/serial_cfg_pkg.sv ====
// Purpose: Shared constants for the three-wire serial master channel
// Assumes: Avalon-MM word addressing, 32-bit data, registers in the low bits
// Notes:   Byte address of a register is four times its word index
package serial_cfg_pkg;

  localparam int unsigned ADDR_W     = 3;
  localparam int unsigned DATA_W     = 32;

  // Register word indices
  localparam logic [2:0]  REG_DATA   = 3'h0;
  localparam logic [2:0]  REG_MODE   = 3'h1;
  localparam logic [2:0]  REG_DIV    = 3'h2;
  localparam logic [2:0]  REG_STAT   = 3'h3;
  localparam logic [2:0]  REG_TRIG   = 3'h4;

  // Mode register fields
  localparam int unsigned MODE_W     = 7;
  localparam int unsigned MODE_IRQ   = 0;
  localparam int unsigned MODE_RX    = 1;
  localparam int unsigned MODE_TX    = 2;
  localparam int unsigned MODE_LSB   = 3;
  localparam int unsigned MODE_LEN7  = 4;
  localparam int unsigned MODE_DAP   = 5;
  localparam int unsigned MODE_CKP   = 6;
  localparam logic [6:0]  MODE_RST   = 7'h06;

  // Divider register fields: half period = (div + 1) << prescale
  localparam int unsigned DIV_LSB    = 0;
  localparam int unsigned DIV_W      = 7;
  localparam int unsigned PRE_LSB    = 8;
  localparam int unsigned PRE_W      = 4;
  localparam logic [6:0]  DIV_RST    = 7'h00;
  localparam logic [3:0]  PRE_RST    = 4'h0;
  localparam int unsigned HALF_W     = 23;

  // Status register bits
  localparam int unsigned STAT_BFF   = 0;
  localparam int unsigned STAT_BUSY  = 1;
  localparam int unsigned STAT_OVF   = 2;
  localparam int unsigned STAT_EN    = 3;
  localparam int unsigned STAT_STOP  = 4;

  // Trigger register bits
  localparam int unsigned TRIG_START = 0;
  localparam int unsigned TRIG_STOP  = 1;
  localparam int unsigned TRIG_CLR   = 2;

  // Word lengths
  localparam logic [3:0]  LEN_7      = 4'h7;
  localparam logic [3:0]  LEN_8      = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_LEAD  = 2'h1,
    ST_SHIFT = 2'h3
  } shift_state_e;

endpackage : serial_cfg_pkg

// ==== hw/half_tick_if.sv ====
// Purpose: Carries the half-period tick between divider and shifter
// Assumes: Both ends on ref_clk
// Notes:   run restarts the divider count from zero when it rises
interface half_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport snk (output run, input tick);
endinterface : half_tick_if

// ==== hw/sck_divider.sv ====
// Purpose: Serial clock half-period tick generator
// Assumes: Divider settings are stable while a word shifts
// Notes:   Non-fast channels clamp the half period to two cycles
module sck_divider #(
  parameter int unsigned FAST_OK = 1
) (
  input  wire logic                                     ref_clk,
  input  wire logic                                     sys_rst,
  input  wire logic [serial_cfg_pkg::DIV_W-1:0]         div_val,
  input  wire logic [serial_cfg_pkg::PRE_W-1:0]         pre_val,
  half_tick_if.src                                      tk
);

  localparam int unsigned HW = serial_cfg_pkg::HALF_W;

  if (FAST_OK > 1) begin : g_bad_fast
    $error("FAST_OK must be 0 or 1");
  end

  logic [HW-1:0] cnt_q;
  logic          tick_q;
  logic [HW-1:0] limit;
  logic [HW-1:0] limit_eff;
  logic          wrap;

  assign limit     = HW'(({{(HW-serial_cfg_pkg::DIV_W){1'b0}}, div_val} + HW'(1)) << pre_val);
  // Only the fastest channel may run one cycle per half period
  assign limit_eff = (FAST_OK == 0 && limit < HW'(2)) ? HW'(2) : limit; // R4 R5
  assign wrap      = cnt_q >= limit_eff - HW'(1);
  assign tk.tick   = tick_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !tk.run) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= wrap ? '0 : cnt_q + HW'(1);
      tick_q <= wrap;
    end
  end

  chk_half_gap: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (FAST_OK == 0 && tick_q) |=> !tick_q) // R4
    else $error("half period shorter than two cycles");

endmodule : sck_divider

// ==== hw/word_shifter.sv ====
// Purpose: Shifts one 7- or 8-bit word out and in under a generated clock
// Assumes: Settings are stable while a word shifts
// Notes:   Normal clock idles high; data launches on the leading edge
module word_shifter (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  half_tick_if.snk        tk,
  input  wire logic       start,
  input  wire logic [7:0] tx_word,
  input  wire logic       tx_en,
  input  wire logic       len7,
  input  wire logic       lsb_first,
  input  wire logic       dap,
  input  wire logic       cpol,
  input  wire logic       sin,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rx_word,
  output logic            sclk,
  output logic            sout
);

  serial_cfg_pkg::shift_state_e state_q;
  logic [4:0] hcnt_q;
  logic       sclk_q;
  logic       sout_q;
  logic       done_q;
  logic [7:0] word_q;
  logic [7:0] rx_q;

  logic [3:0] nbits;
  logic [4:0] last_h;
  logic [3:0] k;
  logic [2:0] idx_cur;
  logic [2:0] idx_nxt;
  logic [2:0] idx_first;
  logic       lead_edge;
  logic       trail_edge;
  logic       is_last;

  function automatic logic [2:0] bit_idx(input logic [3:0] b, input logic lsb, input logic [3:0] n);
    bit_idx = lsb ? b[2:0] : 3'(n - 4'h1 - b); // R9
  endfunction : bit_idx

  assign nbits      = len7 ? serial_cfg_pkg::LEN_7 : serial_cfg_pkg::LEN_8; // R3
  assign last_h     = {nbits, 1'b0} - 5'h01;
  assign k          = hcnt_q[4:1];
  assign idx_cur    = bit_idx(k, lsb_first, nbits);
  assign idx_nxt    = bit_idx(k + 4'h1, lsb_first, nbits);
  assign idx_first  = bit_idx(4'h0, lsb_first, nbits);
  assign lead_edge  = state_q == serial_cfg_pkg::ST_SHIFT && tk.tick && !hcnt_q[0];
  assign trail_edge = state_q == serial_cfg_pkg::ST_SHIFT && tk.tick && hcnt_q[0];
  assign is_last    = hcnt_q == last_h;

  assign tk.run  = state_q != serial_cfg_pkg::ST_IDLE;
  assign busy    = state_q != serial_cfg_pkg::ST_IDLE;
  assign done    = done_q;
  assign rx_word = rx_q;
  assign sclk    = sclk_q;
  assign sout    = sout_q;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= serial_cfg_pkg::ST_IDLE;
      hcnt_q  <= 5'h00;
      sclk_q  <= 1'b1;
      sout_q  <= 1'b1;
      done_q  <= 1'b0;
      word_q  <= 8'h00;
      rx_q    <= 8'h00;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        serial_cfg_pkg::ST_IDLE: begin
          sclk_q <= !cpol; // R8
          hcnt_q <= 5'h00;
          if (start) begin
            word_q  <= tx_word;
            rx_q    <= 8'h00;
            state_q <= dap ? serial_cfg_pkg::ST_LEAD : serial_cfg_pkg::ST_SHIFT;
            if (dap) begin
              // First bit a whole clock (two half periods) ahead of the first clock edge
              sout_q <= tx_en ? tx_word[idx_first] : 1'b1; // R6 R1
            end
          end
        end
        serial_cfg_pkg::ST_LEAD: begin
          if (tk.tick) begin
            state_q <= serial_cfg_pkg::ST_SHIFT;
          end
        end
        serial_cfg_pkg::ST_SHIFT: begin
          if (tk.tick) begin
            sclk_q <= !sclk_q; // R1 R2
            hcnt_q <= hcnt_q + 5'h01;
          end
          if (lead_edge) begin
            if (!dap) begin
              sout_q <= tx_en ? word_q[idx_cur] : 1'b1; // R6
            end else begin
              rx_q[idx_cur] <= sin; // R7 R2
            end
          end
          if (trail_edge) begin
            if (!dap) begin
              rx_q[idx_cur] <= sin; // R7
            end else if (!is_last) begin
              sout_q <= tx_en ? word_q[idx_nxt] : 1'b1;
            end
            if (is_last) begin
              state_q <= serial_cfg_pkg::ST_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= serial_cfg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  sequence s_start_early;
    state_q == serial_cfg_pkg::ST_IDLE && start && dap;
  endsequence

  chk_dap_lead: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_start_early |=> state_q == serial_cfg_pkg::ST_LEAD && sclk_q == !$past(cpol)) // R6
    else $error("early data phase did not hold the clock idle");

  chk_clock_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_q == serial_cfg_pkg::ST_IDLE && $past(state_q) == serial_cfg_pkg::ST_IDLE
    |-> sclk_q == !$past(cpol)) // R8
    else $error("idle clock level does not follow polarity");

endmodule : word_shifter

// ==== hw/three_wire_serial_master.sv ====
// Purpose: Three-wire clocked serial master channel with Avalon-MM registers
// Assumes: ref_clk 200 MHz, sys_rst synchronous active high
// Notes:   Reception-only use still starts each word by a data write
//
// Function
// (R1) Transmit: drive clock and data out
// (R2) Receive: drive clock, sample data in
// (R3) Word length seven or eight bits
// (R4) Fastest clock fclk/2 here, else fclk/4
// (R5) Slowest clock fclk/(2*2^15*128)
// (R6) Output early half clock when phase set
// (R7) Input capture early half clock likewise
// (R8) Polarity bit inverts serial clock
// (R9) MSB or LSB first selectable
// (R10) Interrupt: transfer end or buffer empty
// (R11) Only overrun flagged, receive only
// (R12) Write while full overwrites held data
// (R13) Interrupt source changeable while running
// (R14) Data write starts a transfer
// (R15) Software masks interrupt, then stops
// (R16) After clock removal, software reinitialises
// (R17) Stop trigger clears when disabled
// (R18) Start trigger sets enable status
// (R19) Buffer empty fires on load to shifter
// (R20) Overrun sticky until flag clear trigger
//
// Local design decisions: the register addresses and register access over Avalon-MM.
module three_wire_serial_master #(
  parameter int unsigned UNIT0_CH0 = 1
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 sys_rst,
  input  wire logic [serial_cfg_pkg::ADDR_W-1:0]    address,
  input  wire logic                                 read,
  input  wire logic                                 write,
  input  wire logic [serial_cfg_pkg::DATA_W-1:0]    writedata,
  input  wire logic [3:0]                           byteenable,
  output logic      [serial_cfg_pkg::DATA_W-1:0]    readdata,
  output logic                                      waitrequest,
  output logic                                      channel_irq,
  output logic                                      serial_clock_pin,
  output logic                                      serial_out_pin,
  input  wire logic                                 serial_in_pin
);

  if (UNIT0_CH0 > 1) begin : g_bad_unit
    $error("UNIT0_CH0 must be 0 or 1");
  end

  localparam logic [serial_cfg_pkg::DATA_W-1:0] DATA_W_ZERO = 32'h00000000;

  // Bus slave state
  logic                               waitrequest_q;
  logic [serial_cfg_pkg::DATA_W-1:0]  readdata_q;

  // Channel registers
  logic [serial_cfg_pkg::MODE_W-1:0]  mode_q;
  logic [serial_cfg_pkg::DIV_W-1:0]   div_q;
  logic [serial_cfg_pkg::PRE_W-1:0]   pre_q;
  logic [7:0]                         data_q;
  logic [7:0]                         rx_buf_q;
  logic                               bff_q;
  logic                               rx_full_q;
  logic                               ovf_q;
  logic                               en_q;
  logic                               stop_q;
  logic                               channel_irq_q;
  logic                               sin_meta_q;
  logic                               sin_sync_q;

  // Decode
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        wr_data;
  logic        wr_mode;
  logic        wr_div_lo;
  logic        wr_div_hi;
  logic        wr_trig;
  logic        trig_start;
  logic        trig_stop;
  logic        trig_clr;
  logic        rd_data;
  logic        start;
  logic        busy;
  logic        done;
  logic [7:0]  rx_word;
  logic        irq_src;
  logic        rx_en;
  logic        ovf_set;
  logic [serial_cfg_pkg::DATA_W-1:0] rd_mux;
  logic [serial_cfg_pkg::DATA_W-1:0] stat_word;

  assign req        = read || write;
  assign wr_acc     = write && !waitrequest_q;
  // Read side effects land with the data capture, so no word slips in between
  assign rd_acc     = read && waitrequest_q;
  assign wr_data    = wr_acc && address == serial_cfg_pkg::REG_DATA && byteenable[0];
  assign wr_mode    = wr_acc && address == serial_cfg_pkg::REG_MODE && byteenable[0];
  assign wr_div_lo  = wr_acc && address == serial_cfg_pkg::REG_DIV && byteenable[0];
  assign wr_div_hi  = wr_acc && address == serial_cfg_pkg::REG_DIV && byteenable[1];
  assign wr_trig    = wr_acc && address == serial_cfg_pkg::REG_TRIG && byteenable[0];
  assign trig_start = wr_trig && writedata[serial_cfg_pkg::TRIG_START];
  assign trig_stop  = wr_trig && writedata[serial_cfg_pkg::TRIG_STOP];
  assign trig_clr   = wr_trig && writedata[serial_cfg_pkg::TRIG_CLR];
  assign rd_data    = rd_acc && address == serial_cfg_pkg::REG_DATA;

  assign irq_src    = mode_q[serial_cfg_pkg::MODE_IRQ];
  assign rx_en      = mode_q[serial_cfg_pkg::MODE_RX];
  // A held word goes out once enabled, the shifter is free and no stop is pending
  assign start      = en_q && bff_q && !busy && !stop_q; // R14
  // A finished word lands on an unread one
  assign ovf_set    = done && rx_en && rx_full_q && !rd_data; // R11

  assign stat_word  = DATA_W_ZERO | {
                        27'h0,
                        stop_q,
                        en_q,
                        ovf_q,
                        busy,
                        bff_q};

  always_comb begin
    case (address)
      serial_cfg_pkg::REG_DATA: rd_mux = {24'h000000, rx_buf_q};
      serial_cfg_pkg::REG_MODE: rd_mux = {25'h0, mode_q};
      serial_cfg_pkg::REG_DIV:  rd_mux = {20'h00000, pre_q, 1'b0, div_q};
      serial_cfg_pkg::REG_STAT: rd_mux = stat_word;
      default:                  rd_mux = DATA_W_ZERO;
    endcase
  end

  assign readdata         = readdata_q;
  assign waitrequest      = waitrequest_q;
  assign channel_irq      = channel_irq_q;

  // Every access waits exactly one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      waitrequest_q <= 1'b1;
      readdata_q    <= DATA_W_ZERO;
    end else begin
      waitrequest_q <= !(req && waitrequest_q);
      if (rd_acc) begin
        readdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sin_meta_q <= 1'b1;
      sin_sync_q <= 1'b1;
    end else begin
      sin_meta_q <= serial_in_pin;
      sin_sync_q <= sin_meta_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q <= serial_cfg_pkg::MODE_RST;
      div_q  <= serial_cfg_pkg::DIV_RST;
      pre_q  <= serial_cfg_pkg::PRE_RST;
    end else begin
      if (wr_mode) begin
        mode_q <= writedata[serial_cfg_pkg::MODE_W-1:0]; // R13
      end
      if (wr_div_lo) begin
        div_q <= writedata[serial_cfg_pkg::DIV_LSB +: serial_cfg_pkg::DIV_W];
      end
      if (wr_div_hi) begin
        pre_q <= writedata[serial_cfg_pkg::PRE_LSB +: serial_cfg_pkg::PRE_W];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_q <= 8'h00;
      bff_q  <= 1'b0;
    end else begin
      if (wr_data) begin
        data_q <= writedata[7:0]; // R12 R14
      end
      bff_q <= wr_data || (bff_q && !start); // R12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_q   <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      if (trig_start) begin
        en_q <= 1'b1; // R18
      end else if (stop_q && !busy) begin
        en_q <= 1'b0;
      end
      stop_q <= en_q && (stop_q || trig_stop); // R17
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_buf_q  <= 8'h00;
      rx_full_q <= 1'b0;
      ovf_q     <= 1'b0;
    end else begin
      if (done && rx_en) begin
        rx_buf_q <= rx_word; // R2
      end
      rx_full_q <= (done && rx_en) || (rx_full_q && !rd_data);
      ovf_q     <= ovf_set || (ovf_q && !trig_clr); // R20
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      channel_irq_q <= 1'b0;
    end else begin
      // Source bit is read live, so a late change still applies
      channel_irq_q <= (done && !irq_src) || (start && irq_src); // R10 R13 R19
    end
  end

  half_tick_if tick_link ();

  sck_divider #(
    .FAST_OK (UNIT0_CH0)
  ) u_divider (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .div_val (div_q),
    .pre_val (pre_q),
    .tk      (tick_link)
  );

  word_shifter u_shifter (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .tk        (tick_link),
    .start     (start),
    .tx_word   (data_q),
    .tx_en     (mode_q[serial_cfg_pkg::MODE_TX]),
    .len7      (mode_q[serial_cfg_pkg::MODE_LEN7]),
    .lsb_first (mode_q[serial_cfg_pkg::MODE_LSB]),
    .dap       (mode_q[serial_cfg_pkg::MODE_DAP]),
    .cpol      (mode_q[serial_cfg_pkg::MODE_CKP]),
    .sin       (sin_sync_q),
    .busy      (busy),
    .done      (done),
    .rx_word   (rx_word),
    .sclk      (serial_clock_pin),
    .sout      (serial_out_pin)
  );

  sequence s_load_word;
    start && !wr_data;
  endsequence

  chk_start_load: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_load_word |=> !bff_q ##1 busy) // R14
    else $error("held word not moved into the shifter");

  chk_overwrite: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr_data |=> bff_q && data_q == $past(writedata[7:0])) // R12
    else $error("data write did not replace held word");

  chk_stop_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !en_q |=> !stop_q) // R17
    else $error("stop trigger stayed set while disabled");

  chk_start_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_start |=> en_q) // R18
    else $error("start trigger did not set enable status");

  chk_irq_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done && !irq_src |=> channel_irq_q ##1 !channel_irq_q) // R10
    else $error("transfer end interrupt missing");

  chk_irq_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
    start && irq_src |=> channel_irq_q) // R19
    else $error("buffer empty interrupt missing");

  chk_ovf_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ovf_q && !trig_clr |=> ovf_q) // R20
    else $error("overrun flag dropped without clear");

  chk_ovf_rx_only: assert property (@(posedge ref_clk) disable iff (sys_rst)
    $rose(ovf_q) |-> $past(rx_en) && $past(done) && $past(rx_full_q)) // R11
    else $error("overrun raised without a lost receive word");

  chk_bus_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    req && waitrequest_q |=> !waitrequest_q ##1 waitrequest_q)
    else $error("access not answered after one wait cycle");

endmodule : three_wire_serial_master

// ==== verification/serial_slave_model.sv ====
// Purpose: Behavioural slave on the serial clock and data lines
// Assumes: Its polarity, phase, order and length match the master's
// Notes:   Advances its reply on the capture edge and counts captured bits
module serial_slave_model (
  input  wire logic       ref_clk,
  input  wire logic       clr,
  input  wire logic       cpol,
  input  wire logic       dap,
  input  wire logic       lsb_first,
  input  wire logic       len7,
  input  wire logic [7:0] reply,
  input  wire logic       sclk,
  input  wire logic       din,
  output logic            dout,
  output logic [7:0]      got_word,
  output logic [7:0]      n_samples
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       sclk_q;
  logic [7:0] shift_q;
  logic [2:0] idx_q;
  logic [2:0] last;
  logic       take;
  assign last = len7 ? 3'h6 : 3'h7;
  // Capture edge is the rising one when polarity and phase agree
  assign take = (sclk != sclk_q) && (sclk == (cpol == dap));
  // Next reply bit waits on the line from the previous capture edge on
  assign dout = reply[lsb_first ? idx_q : last - idx_q];
  assign got_word = lsb_first ? (len7 ? {1'h0, shift_q[7:1]} : shift_q) : (shift_q & {~len7, 7'h7F});
  always @(posedge ref_clk) begin
    sclk_q <= sclk;
    if (clr) begin
      idx_q <= 3'h0;
      n_samples <= 8'h00;
    end else if (take) begin
      shift_q <= lsb_first ? {din, shift_q[7:1]} : {shift_q[6:0], din};
      idx_q <= (idx_q == last) ? 3'h0 : idx_q + 3'h1;
      n_samples <= n_samples + 8'h01;
    end
  end
endmodule : serial_slave_model

// ==== verification/three_wire_serial_master_tx_rx_bench.sv ====
// Purpose: Self-checking bench for the three-wire serial master
// Assumes: Half period is (div+1)<<prescale cycles, slave model on the pins
// Notes:   Registers are reached only through Avalon-MM tasks
module three_wire_serial_master_tx_rx_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] R_DATA = serial_cfg_pkg::REG_DATA;
  localparam logic [2:0] R_MODE = serial_cfg_pkg::REG_MODE;
  localparam logic [2:0] R_DIV  = serial_cfg_pkg::REG_DIV;
  localparam logic [2:0] R_STAT = serial_cfg_pkg::REG_STAT;
  localparam logic [2:0] R_TRIG = serial_cfg_pkg::REG_TRIG;
  localparam int         LIMIT  = 20000;
  logic        ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic        clr = 1'h1;
  logic        waitrequest, channel_irq, sclk, sout, sin, sclk_q, cpol, dap, lsb, len7;
  logic [2:0]  address = 3'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd, msk;
  logic [7:0]  reply = 8'h00;
  logic [7:0]  w, got_word, n_samples;
  logic [3:0]  c;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          gap = 0;
  int          min_gap = 1000;
  int          irq_n = 0;
  int          n0;
  int          gap4 = 1000;
  int          min_gap4 = 1000;
  logic        sclk4, sclk4_q;

  three_wire_serial_master #(.UNIT0_CH0(1)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .channel_irq(channel_irq), .serial_clock_pin(sclk), .serial_out_pin(sout), .serial_in_pin(sin));
  // Same channel without the fast option, watched for its clamped clock
  three_wire_serial_master #(.UNIT0_CH0(0)) dut4 (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(), .waitrequest(), .channel_irq(),
    .serial_clock_pin(sclk4), .serial_out_pin(), .serial_in_pin(sin));
  serial_slave_model slave (
    .ref_clk(ref_clk), .clr(clr), .cpol(cpol), .dap(dap), .lsb_first(lsb), .len7(len7), .reply(reply),
    .sclk(sclk), .din(sout), .dout(sin), .got_word(got_word), .n_samples(n_samples));

  always #2.5 ref_clk = ~ref_clk;

  // Shortest spacing of clock toggles, interrupt pulses and the hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    if (sclk !== sclk_q) begin
      if (gap < min_gap) min_gap <= gap;
      gap <= 1;
    end else begin
      gap <= gap + 1;
    end
    if (channel_irq === 1'h1) irq_n <= irq_n + 1;
    sclk4_q <= sclk4;
    if (sclk4 !== sclk4_q) begin
      if (gap4 < min_gap4) min_gap4 <= gap4;
      gap4 <= 1;
    end else begin
      gap4 <= gap4 + 1;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic rw, input logic [2:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= ~rw;
    write <= rw;
    @(posedge ref_clk);
    while (waitrequest !== 1'h0) begin
      @(posedge ref_clk);
    end
    rd = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    int t;
    t = 0;
    bus(1'h0, R_STAT, 32'h0);
    while ((rd & m) !== v && t < 300) begin
      bus(1'h0, R_STAT, 32'h0);
      t++;
    end
    check("status wait", rd & m, v);
  endtask : wait_stat

  task automatic wait_irq(input int n);
    for (int t = 0; t < 400 && irq_n < n; t++) @(posedge ref_clk);
    check("irq count", irq_n, n);
  endtask : wait_irq

  // Mode change may move the idle clock level, so the slave restarts after it
  task automatic setup(input logic [6:0] m);
    bus(1'h1, R_MODE, {25'h0, m});
    clr <= 1'h1;
    @(posedge ref_clk);
    clr <= 1'h0;
    min_gap = 1000;
  endtask : setup

  initial begin
    {len7, lsb, dap, cpol} = 4'h0;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    clr <= 1'h0;
    @(posedge ref_clk);
    check("clock idle", sclk, 1'h1);
    check("data idle", sout, 1'h1);
    bus(1'h0, R_MODE, 32'h0);
    check("mode reset", rd, 32'h6);
    bus(1'h1, R_STAT, 32'h1F);
    bus(1'h0, R_STAT, 32'h0);
    check("status read only", rd, 32'h0);
    bus(1'h0, 3'h5, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'h1, R_TRIG, 32'h1);
    bus(1'h0, R_STAT, 32'h0);
    check("enabled", rd[3], 1'h1);
    bus(1'h1, R_DIV, 32'h3);
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      {len7, lsb, dap, cpol} <= c;
      reply <= 8'h5A ^ (c * 8'h1D);
      w = 8'hC3 + c * 8'h25;
      msk = c[3] ? 32'h7F : 32'hFF;
      setup({c[0], c[1], c[3], c[2], 3'h6});
      n0 = irq_n;
      bus(1'h1, R_DATA, {24'h0, w});
      wait_stat(32'h3, 32'h0);
      check("slave word", got_word, w & msk);
      check("bit count", n_samples, c[3] ? 8'h07 : 8'h08);
      check("clock idle", sclk, !c[0]);
      check("half period", min_gap, 4);
      check("end irq", irq_n, n0 + 1);
      bus(1'h0, R_DATA, 32'h0);
      check("rx word", rd & msk, reply & msk);
    end
    {len7, lsb, dap, cpol} <= 4'h0;
    bus(1'h1, R_DIV, 32'h0);
    setup(7'h04);
    repeat (2) begin
      bus(1'h1, R_DATA, 32'h96);
      wait_stat(32'h3, 32'h0);
    end
    check("fast word", got_word, 8'h96);
    check("fast half period", min_gap, 1);
    check("clamped half period", min_gap4, 2);
    bus(1'h0, R_STAT, 32'h0);
    check("no tx overrun", rd[2], 1'h0);
    bus(1'h1, R_DIV, 32'h201);
    setup(7'h06);
    repeat (2) begin
      bus(1'h1, R_DATA, 32'h3C);
      wait_stat(32'h3, 32'h0);
    end
    check("slow half period", min_gap, 8);
    bus(1'h0, R_STAT, 32'h0);
    check("overrun set", rd[2], 1'h1);
    bus(1'h0, R_DATA, 32'h0);
    bus(1'h0, R_STAT, 32'h0);
    check("overrun held", rd[2], 1'h1);
    bus(1'h1, R_TRIG, 32'h4);
    bus(1'h0, R_STAT, 32'h0);
    check("overrun cleared", rd[2], 1'h0);
    bus(1'h1, R_DIV, 32'h3);
    setup(7'h05);
    n0 = irq_n;
    bus(1'h1, R_DATA, 32'hA1);
    wait_irq(n0 + 1);
    bus(1'h0, R_STAT, 32'h0);
    check("busy after load", rd[1:0], 2'h2);
    bus(1'h1, R_DATA, 32'hB2);
    bus(1'h1, R_DATA, 32'hC3);
    bus(1'h0, R_STAT, 32'h0);
    check("held full", rd[0], 1'h1);
    wait_irq(n0 + 2);
    bus(1'h1, R_MODE, 32'h04);
    wait_stat(32'h3, 32'h0);
    wait_irq(n0 + 3);
    check("frames", n_samples, 8'h10);
    check("last word", got_word, 8'hC3);
    bus(1'h1, R_TRIG, 32'h2);
    wait_stat(32'h8, 32'h0);
    bus(1'h0, R_STAT, 32'h0);
    check("stop cleared", rd[4], 1'h0);
    setup(7'h04);
    bus(1'h1, R_DATA, 32'h69);
    repeat (40) @(posedge ref_clk);
    check("idle while stopped", n_samples, 8'h00);
    bus(1'h0, R_STAT, 32'h0);
    check("held while stopped", rd[0], 1'h1);
    bus(1'h1, R_TRIG, 32'h1);
    wait_stat(32'h3, 32'h0);
    check("word after start", got_word, 8'h69);
    give_verdict();
  end
endmodule : three_wire_serial_master_tx_rx_bench
